// file: nsrt_ctrl.v
/*
  Store/recall sequencer of a serial nonvolatile SRAM: power-up restore, power-loss
  and pin-triggered save, array access lockout, sleep, standby, busy pin drive and
  input spike filtering.
  Assumes the serial protocol engine runs on clk and issues one-cycle requests and
  events; supply monitor, strap and busy pin are asynchronous.
*/
// Summary of operation
// - power-up restore finishes within 20 ms, 40 ms on low-voltage variant
// - skip power-loss and pin saves when no write since last nonvolatile cycle
// - writes stay enabled 25 ns after a save begins
// - ignore array reads and writes during save, restore, and low supply
// - ready within 20 ms (40 ms low-voltage) after wake from sleep
// - enter sleep within 8 ms of the sleep instruction
// - enter standby within 100 us after a bus stop
// - resume array activity within 5 us after busy pin returns high
// - drive busy pin high at most 500 ns before releasing it
// - filter serial clock and data spikes up to 10 ns or 50 ns
`timescale 1ns/100ps
`default_nettype none
`include "nsrt_defines.vh"

module nsrt_ctrl #(
  parameter [`NSRT_CNT_W-1:0] FA_STD_CYC = `NSRT_MS_CYC(`NSRT_T_FA_STD_MS),
  parameter [`NSRT_CNT_W-1:0] FA_LOWV_CYC = `NSRT_MS_CYC(`NSRT_T_FA_LOWV_MS),
  parameter [`NSRT_CNT_W-1:0] WAKE_STD_CYC = `NSRT_MS_CYC(`NSRT_T_WAKE_STD_MS),
  parameter [`NSRT_CNT_W-1:0] WAKE_LOWV_CYC = `NSRT_MS_CYC(`NSRT_T_WAKE_LOWV_MS),
  parameter [`NSRT_CNT_W-1:0] SLEEP_CYC = `NSRT_MS_CYC(`NSRT_T_SLEEP_MS),
  parameter [`NSRT_CNT_W-1:0] STORE_CYC = `NSRT_MS_CYC(`NSRT_T_STORE_MS)
) (
  input wire clk,
  input wire nrst,
  input wire vcc_ok,
  input wire low_v_variant,
  input wire hs_mode,
  input wire scl_in,
  input wire sda_in,
  output wire scl_filt,
  output wire sda_filt,
  input wire hw_save_busy_n_in,
  output reg hw_save_busy_n_out,
  output reg hw_save_busy_n_oe_n,
  input wire array_wr_req,
  input wire array_rd_req,
  output wire array_wr_ack,
  output wire array_rd_ack,
  input wire sleep_cmd,
  input wire wake_req,
  input wire bus_stop,
  input wire bus_start,
  output reg nv_busy_r,
  output reg sleep_state_r,
  output reg standby_state_r,
  output reg write_flag_r
);

  // ----------------------------------------------------------------
  // synchronisers for supply monitor, strap and busy pin
  // ----------------------------------------------------------------
  reg vcc_s1_r;
  reg vcc_r;
  reg lowv_s1_r;
  reg lowv_s2_r;
  reg lowv_r;
  reg pin_s1_r;
  reg pin_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vcc_s1_r <= 1'h0;
      vcc_r <= 1'h0;
      lowv_s1_r <= 1'h0;
      lowv_s2_r <= 1'h0;
      pin_s1_r <= `NSRT_PIN_RST;
      pin_r <= `NSRT_PIN_RST;
    end else begin
      vcc_s1_r <= vcc_ok;
      vcc_r <= vcc_s1_r;
      lowv_s1_r <= low_v_variant;
      lowv_s2_r <= lowv_s1_r;
      pin_s1_r <= hw_save_busy_n_in;
      pin_r <= pin_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // spike filters
  // ----------------------------------------------------------------
  wire [`NSRT_SPW_W-1:0] sp_width;

  localparam integer SPW_HS_I = `NSRT_SP_HS_CYC;
  localparam integer SPW_STD_I = `NSRT_SP_STD_CYC;

  assign sp_width = hs_mode ? SPW_HS_I[`NSRT_SPW_W-1:0] : SPW_STD_I[`NSRT_SPW_W-1:0];

  nsrt_spkflt u_scl_flt (
    .clk(clk),
    .nrst(nrst),
    .raw_in(scl_in),
    .width_cyc(sp_width),
    .filt_r(scl_filt)
  );

  nsrt_spkflt u_sda_flt (
    .clk(clk),
    .nrst(nrst),
    .raw_in(sda_in),
    .width_cyc(sp_width),
    .filt_r(sda_filt)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  reg [`NSRT_ST_W-1:0] state_r;
  reg [`NSRT_ST_W-1:0] state_nxt;
  reg [`NSRT_CNT_W-1:0] cnt_r;
  reg [`NSRT_CNT_W-1:0] cnt_nxt;
  reg [`NSRT_CNT_W-1:0] sb_cnt_r;
  reg sb_pend_r;
  reg hw_src_r;
  reg hw_src_nxt;
  reg nv_done;
  wire rd_ok;
  wire wr_ok;
  wire [`NSRT_CNT_W-1:0] fa_lim;
  wire [`NSRT_CNT_W-1:0] wake_lim;

  // the strap is held from the restore onward; a change later is ignored
  assign fa_lim = lowv_r ? FA_LOWV_CYC : FA_STD_CYC;
  assign wake_lim = lowv_r ? WAKE_LOWV_CYC : WAKE_STD_CYC;

  // access only when idle and powered
  assign rd_ok = (state_r == `NSRT_ST_READY) && vcc_r && pin_r;
  // writes still finish during the save delay
  assign wr_ok = rd_ok || (state_r == `NSRT_ST_DELAY);
  assign array_rd_ack = array_rd_req && rd_ok;
  assign array_wr_ack = array_wr_req && wr_ok;

  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 21'h1;
    hw_src_nxt = hw_src_r;
    nv_done = 1'b0;
    case (state_r)
      `NSRT_ST_OFF: begin
        cnt_nxt = {`NSRT_CNT_W{1'b0}};
        if (vcc_r) begin
          state_nxt = `NSRT_ST_RESTORE;
        end
      end
      `NSRT_ST_RESTORE: begin
        if (!vcc_r) begin
          state_nxt = `NSRT_ST_OFF;
        end else if (cnt_r >= fa_lim - 21'h1) begin
          state_nxt = `NSRT_ST_READY;
          nv_done = 1'b1;
        end
      end
      `NSRT_ST_READY, `NSRT_ST_SLEEP: begin
        cnt_nxt = {`NSRT_CNT_W{1'b0}};
        if (!vcc_r || !pin_r) begin
          hw_src_nxt = vcc_r;
          if (write_flag_r) begin
            state_nxt = `NSRT_ST_DELAY;
          end else begin
            state_nxt = vcc_r ? `NSRT_ST_HWWAIT : `NSRT_ST_OFF;
          end
        end else if (state_r == `NSRT_ST_SLEEP) begin
          if (wake_req) begin
            state_nxt = `NSRT_ST_WAKE;
          end
        end else if (sleep_cmd) begin
          state_nxt = `NSRT_ST_SLPENT;
        end
      end
      `NSRT_ST_DELAY: begin
        if (cnt_r >= `NSRT_DELAY_CYC - 1) begin
          state_nxt = `NSRT_ST_STORE;
          cnt_nxt = {`NSRT_CNT_W{1'b0}};
        end
      end
      `NSRT_ST_STORE: begin
        if (cnt_r >= STORE_CYC - 21'h1) begin
          nv_done = 1'b1;
          cnt_nxt = {`NSRT_CNT_W{1'b0}};
          state_nxt = hw_src_r ? `NSRT_ST_RELEASE : `NSRT_ST_OFF;
        end
      end
      `NSRT_ST_RELEASE: begin
        if (cnt_r >= `NSRT_HHHD_CYC - 1) begin
          state_nxt = vcc_r ? `NSRT_ST_HWWAIT : `NSRT_ST_OFF;
          cnt_nxt = {`NSRT_CNT_W{1'b0}};
        end
      end
      `NSRT_ST_HWWAIT: begin
        // resume once the pin is seen high
        if (!vcc_r) begin
          state_nxt = `NSRT_ST_OFF;
        // the synchroniser still shows our own high drive for two cycles
        end else if (pin_r && (cnt_r >= 21'h2)) begin
          state_nxt = `NSRT_ST_READY;
        end
      end
      `NSRT_ST_SLPENT: begin
        if (!vcc_r) begin
          state_nxt = `NSRT_ST_READY;
        end else if (cnt_r >= SLEEP_CYC - 21'h1) begin
          state_nxt = `NSRT_ST_SLEEP;
        end
      end
      `NSRT_ST_WAKE: begin
        if (!vcc_r) begin
          state_nxt = `NSRT_ST_OFF;
        end else if (cnt_r >= wake_lim - 21'h1) begin
          state_nxt = `NSRT_ST_READY;
        end
      end
      default: begin
        state_nxt = `NSRT_ST_OFF;
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= `NSRT_ST_OFF;
      cnt_r <= {`NSRT_CNT_W{1'b0}};
      hw_src_r <= 1'h0;
      lowv_r <= 1'h0;
      write_flag_r <= 1'h0;
      nv_busy_r <= 1'h1;
      sleep_state_r <= 1'h0;
      hw_save_busy_n_out <= 1'h0;
      hw_save_busy_n_oe_n <= 1'h1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      hw_src_r <= hw_src_nxt;
      if (state_r == `NSRT_ST_OFF) begin
        lowv_r <= lowv_s2_r;
      end
      if (array_wr_ack) begin
        write_flag_r <= 1'h1;
      end else if (nv_done) begin
        write_flag_r <= 1'h0;
      end
      nv_busy_r <= (state_nxt != `NSRT_ST_READY) && (state_nxt != `NSRT_ST_SLEEP);
      sleep_state_r <= (state_nxt == `NSRT_ST_SLEEP);
      // pin low through delay and store, high briefly after a pin-triggered save, else released
      hw_save_busy_n_out <= (state_nxt == `NSRT_ST_RELEASE);
      hw_save_busy_n_oe_n <= !((state_nxt == `NSRT_ST_DELAY) ||
                               (state_nxt == `NSRT_ST_STORE) ||
                               (state_nxt == `NSRT_ST_RELEASE));
    end
  end

  // ----------------------------------------------------------------
  // standby after bus stop
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sb_cnt_r <= {`NSRT_CNT_W{1'b0}};
      sb_pend_r <= 1'h0;
      standby_state_r <= 1'h0;
    end else begin
      if (bus_start || state_r != `NSRT_ST_READY) begin
        sb_pend_r <= 1'h0;
        standby_state_r <= 1'h0;
        sb_cnt_r <= {`NSRT_CNT_W{1'b0}};
      end else if (bus_stop) begin
        sb_pend_r <= 1'h1;
        sb_cnt_r <= {`NSRT_CNT_W{1'b0}};
      end else if (sb_pend_r) begin
        sb_cnt_r <= sb_cnt_r + 21'h1;
        if (sb_cnt_r >= `NSRT_SB_CYC - 1) begin
          sb_pend_r <= 1'h0;
          standby_state_r <= 1'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: nsrt_defines.vh
/*
  Constants for the store/recall sequencer: clock rate, documented times and the
  cycle counts derived from them, state codes.
  Assumes a 40 MHz core clock; included by bare name.
*/
`ifndef NSRT_DEFINES_VH
`define NSRT_DEFINES_VH

// ----------------------------------------------------------------
// clock and times in their own units
// ----------------------------------------------------------------
`define NSRT_CLK_NS 25
`define NSRT_T_DELAY_NS 25
`define NSRT_T_HHHD_NS 500
`define NSRT_T_SB_NS 100000
`define NSRT_T_LZHSB_NS 5000
`define NSRT_T_SP_HS_NS 10
`define NSRT_T_SP_STD_NS 50
`define NSRT_T_FA_STD_MS 20
`define NSRT_T_FA_LOWV_MS 40
`define NSRT_T_WAKE_STD_MS 20
`define NSRT_T_WAKE_LOWV_MS 40
`define NSRT_T_SLEEP_MS 8
`define NSRT_T_STORE_MS 8

// ----------------------------------------------------------------
// derived counts: longest times round down, never below one cycle
// ----------------------------------------------------------------
`define NSRT_MIN1(x) (((x) < 1) ? 1 : (x))
`define NSRT_DELAY_CYC `NSRT_MIN1(`NSRT_T_DELAY_NS / `NSRT_CLK_NS)
`define NSRT_HHHD_CYC `NSRT_MIN1(`NSRT_T_HHHD_NS / `NSRT_CLK_NS)
`define NSRT_SB_CYC `NSRT_MIN1(`NSRT_T_SB_NS / `NSRT_CLK_NS)
`define NSRT_LZHSB_CYC `NSRT_MIN1(`NSRT_T_LZHSB_NS / `NSRT_CLK_NS)
`define NSRT_SP_HS_CYC `NSRT_MIN1(`NSRT_T_SP_HS_NS / `NSRT_CLK_NS)
`define NSRT_SP_STD_CYC `NSRT_MIN1(`NSRT_T_SP_STD_NS / `NSRT_CLK_NS)
`define NSRT_MS_CYC(ms) (((ms) * 1000000) / `NSRT_CLK_NS)

// ----------------------------------------------------------------
// widths, reset values, state codes
// ----------------------------------------------------------------
`define NSRT_CNT_W 21
`define NSRT_SPW_W 3
`define NSRT_ST_W 4
`define NSRT_ST_OFF 4'h0
`define NSRT_ST_RESTORE 4'h1
`define NSRT_ST_READY 4'h2
`define NSRT_ST_DELAY 4'h3
`define NSRT_ST_STORE 4'h4
`define NSRT_ST_RELEASE 4'h5
`define NSRT_ST_HWWAIT 4'h6
`define NSRT_ST_SLPENT 4'h7
`define NSRT_ST_SLEEP 4'h8
`define NSRT_ST_WAKE 4'h9
`define NSRT_PIN_RST 1'h1

`endif

// file: nsrt_spkflt.v
/*
  Spike filter for one serial bus input: two-flop synchroniser, then a level is
  accepted only after it has been sampled width_cyc+1 times in a row.
  Assumes the input idles high, as an open-drain bus line does.
*/
`timescale 1ns/100ps
`default_nettype none
`include "nsrt_defines.vh"

module nsrt_spkflt (
  input wire clk,
  input wire nrst,
  input wire raw_in,
  input wire [`NSRT_SPW_W-1:0] width_cyc,
  output reg filt_r
);

  reg sync1_r;
  reg sync2_r;
  reg [`NSRT_SPW_W-1:0] cnt_r;

  // ----------------------------------------------------------------
  // synchronise, then require a stable run longer than the spike width
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= `NSRT_PIN_RST;
      sync2_r <= `NSRT_PIN_RST;
      cnt_r <= {`NSRT_SPW_W{1'b0}};
      filt_r <= `NSRT_PIN_RST;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      if (sync2_r == filt_r) begin
        cnt_r <= {`NSRT_SPW_W{1'b0}};
      end else if (cnt_r >= width_cyc) begin
        filt_r <= sync2_r;
        cnt_r <= {`NSRT_SPW_W{1'b0}};
      end else begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

endmodule
`default_nettype wire

// file: nsrt_ctrl_props.sv
/*
  Port checker for the store/recall sequencer.
  Assumes binding onto nsrt_ctrl with the same shortened count parameters.
*/
`timescale 1ns/100ps
`default_nettype none
module nsrt_ctrl_props #(
  parameter [20:0] FA_STD_CYC = 21'h3c,
  parameter [20:0] FA_LOWV_CYC = 21'h5a,
  parameter [20:0] WAKE_STD_CYC = 21'h32,
  parameter [20:0] WAKE_LOWV_CYC = 21'h46,
  parameter [20:0] SLEEP_CYC = 21'h28
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic vcc_ok,
  input wire logic hw_save_busy_n_in,
  input wire logic hw_save_busy_n_out,
  input wire logic hw_save_busy_n_oe_n,
  input wire logic array_wr_req,
  input wire logic array_rd_req,
  input wire logic array_wr_ack,
  input wire logic array_rd_ack,
  input wire logic sleep_cmd,
  input wire logic wake_req,
  input wire logic bus_stop,
  input wire logic bus_start,
  input wire logic nv_busy_r,
  input wire logic sleep_state_r,
  input wire logic standby_state_r,
  input wire logic write_flag_r
);
  localparam int FA_MIN = FA_STD_CYC;
  localparam int FA_MAX = FA_LOWV_CYC + 4;
  localparam int WK_MIN = WAKE_STD_CYC - 4;
  localparam int WK_MAX = WAKE_LOWV_CYC + 4;
  localparam int SL_MAX = SLEEP_CYC + 3;
  logic [12:0] sb_cnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // standby wait, counted here since it is too long to unroll
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) sb_cnt_r <= 13'h0;
    else if (bus_start || nv_busy_r || sleep_state_r) sb_cnt_r <= 13'h0;
    else if (bus_stop) sb_cnt_r <= 13'h1;
    else if (sb_cnt_r != 13'h0 && sb_cnt_r < 13'h1000) sb_cnt_r <= sb_cnt_r + 13'h1;
  end
  sequence drv_low_s;
    !hw_save_busy_n_oe_n && !hw_save_busy_n_out;
  endsequence
  sequence drv_high_s;
    !hw_save_busy_n_oe_n && hw_save_busy_n_out;
  endsequence
  rd_lockout_a: assert property (
    array_rd_ack |-> array_rd_req && !nv_busy_r && !sleep_state_r) else $error("read acked");
  wr_flag_a: assert property (
    array_wr_ack |-> array_wr_req ##1 write_flag_r) else $error("write not flagged");
  write_window_a: assert property (
    $fell(hw_save_busy_n_oe_n) |=> !array_wr_ack[*2]) else $error("write past window");
  restore_time_a: assert property (
    $rose(vcc_ok) |-> ##[FA_MIN:FA_MAX] !nv_busy_r) else $error("restore too long");
  wake_time_a: assert property (
    sleep_state_r && wake_req |=> nv_busy_r ##[WK_MIN:WK_MAX] !nv_busy_r)
    else $error("wake too long");
  sleep_entry_a: assert property (
    sleep_cmd && !nv_busy_r && !sleep_state_r |-> ##[1:SL_MAX] sleep_state_r)
    else $error("sleep late");
  skip_save_a: assert property (
    $rose(nv_busy_r) && !write_flag_r && !$past(write_flag_r) |-> hw_save_busy_n_oe_n[*4])
    else $error("needless save");
  release_drive_a: assert property (
    drv_low_s ##1 drv_high_s |-> ##[1:20] hw_save_busy_n_oe_n) else $error("drive too long");
  pin_resume_a: assert property (
    nv_busy_r && hw_save_busy_n_oe_n && vcc_ok && $rose(hw_save_busy_n_in) && !sleep_state_r
    |-> ##[1:200] !nv_busy_r) else $error("resume late");
  standby_entry_a: assert property (
    sb_cnt_r == 13'hfa3 |-> standby_state_r) else $error("standby late");
endmodule
bind nsrt_ctrl nsrt_ctrl_props #(.FA_STD_CYC(FA_STD_CYC), .FA_LOWV_CYC(FA_LOWV_CYC),
  .WAKE_STD_CYC(WAKE_STD_CYC), .WAKE_LOWV_CYC(WAKE_LOWV_CYC), .SLEEP_CYC(SLEEP_CYC))
  nsrt_ctrl_props_i (.clk(clk), .nrst(nrst), .vcc_ok(vcc_ok),
  .hw_save_busy_n_in(hw_save_busy_n_in), .hw_save_busy_n_out(hw_save_busy_n_out),
  .hw_save_busy_n_oe_n(hw_save_busy_n_oe_n), .array_wr_req(array_wr_req),
  .array_rd_req(array_rd_req), .array_wr_ack(array_wr_ack), .array_rd_ack(array_rd_ack),
  .sleep_cmd(sleep_cmd), .wake_req(wake_req), .bus_stop(bus_stop), .bus_start(bus_start),
  .nv_busy_r(nv_busy_r), .sleep_state_r(sleep_state_r),
  .standby_state_r(standby_state_r), .write_flag_r(write_flag_r));
`default_nettype wire

// file: nsrt_i2cm.sv
/*
  Bus master stand-in: frames on the two serial lines, and spikes.
  Assumes the lines idle high through pull-ups; the clock is still between frames.
*/
`timescale 1ns/100ps
`default_nettype none
module nsrt_i2cm (
  output var logic scl,
  output var logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // start, nine bits at 200 ns a bit, stop
  task automatic frame(input logic [8:0] bits);
    begin
      sda = 1'b0;
      #100;
      for (int i = 8; i >= 0; i--) begin
        scl = 1'b0;
        #50 sda = bits[i];
        #50 scl = 1'b1;
        #100;
      end
      scl = 1'b0;
      #50 sda = 1'b0;
      #50 scl = 1'b1;
      #100 sda = 1'b1;
      #100;
    end
  endtask
  task automatic spike(input logic on_scl, input int w);
    begin
      if (on_scl) scl = 1'b0;
      else sda = 1'b0;
      #w;
      scl = 1'b1;
      sda = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// file: nsrt_ctrl_bench.sv
/*
  Self-checking bench for nsrt_ctrl with shortened counts.
  Assumes the bus master stand-in and the bound port checker.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, s); end end
module nsrt_ctrl_bench;
  localparam logic [20:0] FA = 21'h3c, FAL = 21'h5a, WK = 21'h32, WKL = 21'h46;
  localparam logic [20:0] SL = 21'h28, ST = 21'h1e;
  logic clk = 1'b0, nrst = 1'b0, vcc_ok = 1'b0, low_v = 1'b0, hs = 1'b0, pull = 1'b1;
  logic wr = 1'b0, rd = 1'b0, slp = 1'b0, wake = 1'b0, stp = 1'b0, sta = 1'b0;
  logic [1:0] e;
  logic [1:0] exp_q[$];
  int bad_count = 0, total_checks = 0, cyc = 0, rises = 0, hi = 0, n = 0;
  wire scl, sda, scl_f, sda_f, pin_o, pin_oe_n, wr_ack, rd_ack, busy, sleep_s, stby, wflag;
  // open-drain busy pin: device drive, else bench pulls low, else pull-up
  wire pin = !pin_oe_n ? pin_o : pull;
  nsrt_i2cm nsrt_i2cm_i (.scl(scl), .sda(sda));
  nsrt_ctrl #(.FA_STD_CYC(FA), .FA_LOWV_CYC(FAL), .WAKE_STD_CYC(WK), .WAKE_LOWV_CYC(WKL),
    .SLEEP_CYC(SL), .STORE_CYC(ST)) nsrt_ctrl_i (.clk(clk), .nrst(nrst), .vcc_ok(vcc_ok),
    .low_v_variant(low_v), .hs_mode(hs), .scl_in(scl), .sda_in(sda), .scl_filt(scl_f),
    .sda_filt(sda_f), .hw_save_busy_n_in(pin), .hw_save_busy_n_out(pin_o),
    .hw_save_busy_n_oe_n(pin_oe_n), .array_wr_req(wr), .array_rd_req(rd),
    .array_wr_ack(wr_ack), .array_rd_ack(rd_ack), .sleep_cmd(slp), .wake_req(wake),
    .bus_stop(stp), .bus_start(sta), .nv_busy_r(busy), .sleep_state_r(sleep_s),
    .standby_state_r(stby), .write_flag_r(wflag));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // monitor: every ack must match the oldest expected access
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr_ack || rd_ack) begin
      e = exp_q.size() ? exp_q.pop_front() : 2'h0;
      `CHK("ack", e, {wr_ack, rd_ack})
    end
    if (!pin_oe_n && pin_o) hi++;
    if (cyc > 20000) begin
      bad_count++;
      final_report();
    end
  end
  always @(posedge scl_f) rises++;
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic acc(input logic w, input logic r, input logic ok);
    wr = w;
    rd = r;
    if (ok) exp_q.push_back({w, r});
    tick(1);
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic wait_ready;
    n = 0;
    hi = 0;
    while (busy !== 1'b0 && n < 2000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    n = $urandom(13505);
    tick(5);
    nrst = 1'b1;
    tick(2);
    vcc_ok = 1'b1;
    rd = 1'b1;
    tick(20);
    rd = 1'b0;
    wait_ready();
    `CHK("restore", 1'h1, n + 20 >= FA && n + 20 <= FA + 4)
    for (int i = 0; i < 24; i++) begin
      n = $urandom;
      wr = n[0] | (i == 23);
      rd = n[1];
      if (wr || rd) exp_q.push_back({wr, rd});
      tick(1);
    end
    wr = 1'b0;
    rd = 1'b0;
    `CHK("write flag", 1'h1, wflag)
    $display("restore and access test done");
    for (int m = 0; m < 2; m++) begin
      hs = m[0];
      tick(4);
      nsrt_i2cm_i.spike(m[0], m ? 10 : 50);
      repeat (6) begin
        tick(1);
        `CHK("filtered line", 2'h3, {scl_f, sda_f})
      end
      rises = 0;
      nsrt_i2cm_i.frame(9'h0a5);
      tick(8);
      `CHK("clock rises", 10, rises)
    end
    $display("filter test done");
    pulse(stp);
    tick(3990);
    `CHK("standby", 1'h0, stby)
    tick(20);
    `CHK("standby", 1'h1, stby)
    pulse(sta);
    tick(2);
    `CHK("standby", 1'h0, stby)
    $display("standby test done");
    pulse(slp);
    acc(1'b0, 1'b1, 1'b0);
    tick(SL + 3);
    `CHK("sleep", 1'h1, sleep_s)
    acc(1'b0, 1'b1, 1'b0);
    pulse(wake);
    wait_ready();
    `CHK("wake", 1'h1, n + 1 >= WK && n <= WK + 4)
    $display("sleep test done");
    acc(1'b1, 1'b0, 1'b1);
    pull = 1'b0;
    tick(4);
    `CHK("pin drive", 2'h0, {pin_oe_n, pin_o})
    pull = 1'b1;
    acc(1'b0, 1'b1, 1'b0);
    wait_ready();
    `CHK("high drive", 1'h1, hi >= 1 && hi <= 20)
    `CHK("write flag", 1'h0, wflag)
    pull = 1'b0;
    tick(6);
    `CHK("pin drive", 1'h1, pin_oe_n)
    acc(1'b1, 1'b0, 1'b0);
    pull = 1'b1;
    wait_ready();
    `CHK("pin resume", 1'h1, n <= 200 && wflag === 1'b0)
    $display("pin save test done");
    acc(1'b1, 1'b0, 1'b1);
    vcc_ok = 1'b0;
    low_v = 1'b1;
    tick(3);
    acc(1'b1, 1'b0, 1'b1);
    `CHK("pin drive", 1'h0, pin_oe_n)
    tick(ST + 4);
    `CHK("write flag", 1'h0, wflag)
    acc(1'b0, 1'b1, 1'b0);
    vcc_ok = 1'b1;
    wait_ready();
    `CHK("restore", 1'h1, n >= FAL && n <= FAL + 4)
    vcc_ok = 1'b0;
    low_v = 1'b0;
    tick(6);
    `CHK("pin drive", 1'h1, pin_oe_n)
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    vcc_ok = 1'b1;
    wait_ready();
    `CHK("restore", 1'h1, n >= FA && n <= FA + 4)
    `CHK("queue", 0, exp_q.size())
    $display("power loss test done");
    final_report();
  end
endmodule
`default_nettype wire
